// [prsc_pkg.sv]
/*
 * prsc_pkg: register map, field positions, reset values and carrier types
 * of the power, reset and sync control block.
 * assumes: one clock domain; the serial framing engine sits outside.
 */
package prsc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SPORT_CFG = 7'h00;
    localparam logic [6:0] ADDR_PLL_PD    = 7'h0a;
    localparam logic [6:0] ADDR_OUT_FIRST = 7'h3c;
    localparam logic [6:0] ADDR_FSP_CTRL  = 7'h58;
    localparam logic [6:0] ADDR_UPDATE    = 7'h5a;

    // staged register bank: index 0 pll, 1..8 outputs, 9 function/sync/power
    localparam int          N_STAGED    = 10;
    localparam int          IDX_PLL     = 0;
    localparam int          IDX_OUT0    = 1;
    localparam int          IDX_FSP     = 9;
    localparam int          N_OUTS      = 8;
    localparam int          N_PECL      = 4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SDO_EN     = 7;
    localparam int BIT_LSB_FIRST  = 6;
    localparam int BIT_SOFT_RST   = 5;
    localparam int BIT_UPDATE     = 0;
    localparam int LSB_PLL_PD     = 0;
    localparam int LSB_FUNC_SEL   = 5;
    localparam int BIT_DIST_PD    = 3;
    localparam int BIT_SOFT_SYNC  = 2;
    localparam int BIT_SYNC_WIN   = 1;
    localparam int BIT_MC_SYNC_EN = 0;
    localparam int LSB_PECL_MODE  = 0;
    localparam int BIT_CMOS_PD    = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SPORT_CFG = 8'h00;
    localparam logic [7:0] RST_PLL_PD    = 8'h00;
    localparam logic [7:0] RST_OUT       = 8'h00;
    localparam logic [7:0] RST_FSP_CTRL  = 8'h00;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] PLL_PD_ASYNC   = 2'h1;
    localparam logic [1:0] PLL_PD_SYNC    = 2'h3;
    localparam logic [1:0] FUNC_HARD_RST  = 2'h0;
    localparam logic [1:0] FUNC_PIN_SYNC  = 2'h1;
    localparam logic [1:0] FUNC_SLEEP     = 2'h3;
    localparam logic [1:0] PECL_NORMAL    = 2'h0;
    localparam logic [1:0] PECL_SAFE_OFF  = 2'h2;

    // slow-clock edge separation allowed, in whole fast-clock cycles
    localparam logic [1:0] SYNC_WIN_WIDE_CYC   = 2'h1;
    localparam logic [1:0] SYNC_WIN_NARROW_CYC = 2'h0;

    typedef enum logic [1:0] {
        MON_IDLE     = 2'b00,
        MON_WAIT_REF = 2'b01,
        MON_WAIT_AUX = 2'b10
    } prsc_mon_t;

    typedef struct packed {
        logic                  pll_off;
        logic                  dist_off;
        logic                  clocks_off;
        logic                  dividers_off;
        logic                  sync_hold;
        logic [N_OUTS-1:0]     out_off;
        logic [N_PECL-1:0][1:0] pecl_mode;
    } prsc_power_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } prsc_reg_req_t;

endpackage : prsc_pkg

// [prsc_stage_reg.sv]
/*
 * prsc_stage_reg: one register with a write buffer and an active copy.
 * assumes: update is a one-cycle pulse on the same clock as writes.
 */
`timescale 1ns/1ps
`default_nettype none

module prsc_stage_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_update,
    output logic [7:0]      o_buf,
    output logic [7:0]      o_act
);

    logic [7:0] buf_q;
    logic [7:0] act_q;
    logic [7:0] buf_d;

    // a write in the update cycle still joins that update
    assign buf_d = i_wr ? i_wdata : buf_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            buf_q <= RST_VAL;
            act_q <= RST_VAL;
        end else begin
            buf_q <= buf_d;
            if (i_update) begin
                act_q <= buf_d;
            end
        end
    end

    assign o_buf = buf_q;
    assign o_act = act_q;

endmodule : prsc_stage_reg

`default_nettype wire

// [prsc_top.sv]
/*
 * prsc_top: power-down, reset and sync control of a clock distributor.
 * holds the serial-port config register, the staged control registers,
 * sleep / hard reset / pin sync decode of the multipurpose pin and the
 * multichip slow-clock coincidence monitor.
 * assumes: the serial framing engine hands over byte writes and reads;
 * i_ref_clk is the fast clock; pins and slow clocks are asynchronous.
 */
// Notes on behaviour
// - sleep code selected and pin low puts chip asleep until pin high.
// - waking keeps register contents, including anything written while asleep.
// - sleep stops pll, clocks, sync, dividers, lvds/cmos; lvpecl safe-off.
// - register port keeps accepting and answering during sleep.
// - pll field: 00/10 normal, 01 async power-down, 11 sync power-down.
// - async pll power-down acts as soon as the update lands.
// - sync pll power-down waits for next charge-pump event after update.
// - distribution power-down bit removes bias from distribution section.
// - lvpecl mode 00 normal, 10 protected off, 11 unprotected off.
// - each of eight outputs has its own power-down bit or mode.
// - power-on reset loads every register default.
// - function select 00: pin low is a hard reset to defaults.
// - soft-reset bit resets every register except the config register.
// - soft-reset bit never clears itself; host must write zero.
// - function select 01: pin low holds outputs, release restarts together.
// - soft-sync bit holds outputs while one, releases on zero.
// - multichip enable puts sync flag on status pin, high means out.
// - window bit zero allows one cycle separation, one allows half; the code allows zero whole cycles for one.
// - flag high when slow edges separate beyond window, low within.
// - writes buffer until update bit; update self-clears, applies all.
`timescale 1ns/1ps
`default_nettype none

module prsc_top (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire prsc_pkg::prsc_reg_req_t i_req,
    input  wire logic [6:0]            i_rd_addr,
    output logic [7:0]                 o_rd_data,
    input  wire logic                  i_function_pin,
    input  wire logic                  i_reference_input,
    input  wire logic                  i_aux_clock_input,
    input  wire logic                  i_cp_event,
    output logic                       o_status,
    output logic                       o_sleep,
    output logic                       o_sdo_enable,
    output logic                       o_lsb_first,
    output prsc_pkg::prsc_power_t      o_power
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_sync_q;
    logic [2:0] ref_sync_q;
    logic [2:0] aux_sync_q;

    always_ff @(posedge i_ref_clk) begin
        pin_sync_q <= {pin_sync_q[1:0], i_function_pin};
        ref_sync_q <= {ref_sync_q[1:0], i_reference_input};
        aux_sync_q <= {aux_sync_q[1:0], i_aux_clock_input};
    end

    logic pin_low;
    logic ref_rise;
    logic aux_rise;

    assign pin_low  = ~pin_sync_q[1];
    assign ref_rise = ref_sync_q[1] & ~ref_sync_q[2];
    assign aux_rise = aux_sync_q[1] & ~aux_sync_q[2];

    // ------------------------------------------------------------
    // resets
    // ------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] fsp_act;
    logic [1:0] func_sel;
    logic       hard_rst;
    logic       cfg_rst;
    logic       stage_rst;
    logic       soft_rst;

    assign func_sel = fsp_act[prsc_pkg::LSB_FUNC_SEL +: 2];
    // pin reset is seen after the synchroniser, two cycles late
    assign hard_rst = (func_sel == prsc_pkg::FUNC_HARD_RST) & pin_low;
    assign cfg_rst  = i_rst | hard_rst;
    assign soft_rst = cfg_q[prsc_pkg::BIT_SOFT_RST];
    // held for as long as the bit reads one
    assign stage_rst = cfg_rst | soft_rst;

    // ------------------------------------------------------------
    // serial port config register, acts at once
    // ------------------------------------------------------------
    logic cfg_hit;

    assign cfg_hit = i_req.wr & (i_req.addr == prsc_pkg::ADDR_SPORT_CFG);
    // no self-clear: only a host write or a reset (power-on or pin) changes the soft-reset bit
    assign cfg_d   = cfg_hit ? i_req.wdata : cfg_q;

    always_ff @(posedge i_ref_clk) begin
        if (cfg_rst) begin
            cfg_q <= prsc_pkg::RST_SPORT_CFG;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // update strobe
    // ------------------------------------------------------------
    logic update;

    // pulse only; the bit itself is never stored so it reads back zero
    assign update = i_req.wr & (i_req.addr == prsc_pkg::ADDR_UPDATE)
                  & i_req.wdata[prsc_pkg::BIT_UPDATE];

    // ------------------------------------------------------------
    // staged register bank
    // ------------------------------------------------------------
    logic [prsc_pkg::N_STAGED-1:0][7:0] bank_buf;
    logic [prsc_pkg::N_STAGED-1:0][7:0] bank_act;
    logic [prsc_pkg::N_STAGED-1:0][7:0] bank_rd;
    logic [prsc_pkg::N_STAGED-1:0]      bank_hit;

    genvar g;
    generate
        for (g = 0; g < prsc_pkg::N_STAGED; g++) begin : g_bank
            localparam logic [6:0] ADDR =
                (g == prsc_pkg::IDX_PLL) ? prsc_pkg::ADDR_PLL_PD :
                (g == prsc_pkg::IDX_FSP) ? prsc_pkg::ADDR_FSP_CTRL :
                prsc_pkg::ADDR_OUT_FIRST + 7'(g - prsc_pkg::IDX_OUT0);
            localparam logic [7:0] RSTV =
                (g == prsc_pkg::IDX_PLL) ? prsc_pkg::RST_PLL_PD :
                (g == prsc_pkg::IDX_FSP) ? prsc_pkg::RST_FSP_CTRL :
                prsc_pkg::RST_OUT;
            logic wr_hit;
            logic rd_hit;

            assign wr_hit = i_req.wr & (i_req.addr == ADDR);
            assign rd_hit = (i_rd_addr == ADDR);
            assign bank_hit[g] = rd_hit;
            // reads return the buffer, not the active copy
            assign bank_rd[g] = bank_hit[g] ? bank_buf[g] : 8'h00;

            // writes keep landing in the buffer while asleep
            prsc_stage_reg #(
                .RST_VAL (RSTV)
            ) u_reg (
                .i_ref_clk (i_ref_clk),
                .i_rst     (stage_rst),
                .i_wr      (wr_hit),
                .i_wdata   (i_req.wdata),
                .i_update  (update),
                .o_buf     (bank_buf[g]),
                .o_act     (bank_act[g])
            );
        end
    endgenerate

    assign fsp_act = bank_act[prsc_pkg::IDX_FSP];

    // ------------------------------------------------------------
    // read-back
    // ------------------------------------------------------------
    logic [7:0] rd_bank;
    logic [7:0] rd_d;
    logic [7:0] rd_q;
    logic       rd_cfg;

    always_comb begin
        rd_bank = 8'h00;
        for (int i = 0; i < prsc_pkg::N_STAGED; i++) begin
            rd_bank = rd_bank | bank_rd[i];
        end
    end

    assign rd_cfg = (i_rd_addr == prsc_pkg::ADDR_SPORT_CFG);
    // unmapped addresses and the update register read as zero
    assign rd_d   = rd_cfg ? cfg_q : rd_bank;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // sleep and sync hold
    // ------------------------------------------------------------
    logic sleep;
    logic pin_hold;
    logic soft_hold;
    logic sync_hold;

    // sleep code is a package constant, free to move
    assign sleep     = (func_sel == prsc_pkg::FUNC_SLEEP) & pin_low;
    assign pin_hold  = (func_sel == prsc_pkg::FUNC_PIN_SYNC) & pin_low;
    assign soft_hold = fsp_act[prsc_pkg::BIT_SOFT_SYNC];
    assign sync_hold = pin_hold | soft_hold;

    // ------------------------------------------------------------
    // pll power-down
    // ------------------------------------------------------------
    logic [1:0] pll_mode;
    logic       pll_pd_q;
    logic       pll_pd_d;
    logic       pll_arm_q;
    logic       pll_arm_d;
    logic       upd_q;

    assign pll_mode = bank_act[prsc_pkg::IDX_PLL][prsc_pkg::LSB_PLL_PD +: 2];

    // the active copy shows the new mode one edge after the update strobe,
    // so arming looks at the delayed strobe; fire on next charge pump
    assign pll_arm_d = (pll_mode != prsc_pkg::PLL_PD_SYNC) ? 1'b0 :
                       upd_q ? 1'b1 :
                       (pll_arm_q & ~i_cp_event);
    assign pll_pd_d  = (pll_mode == prsc_pkg::PLL_PD_ASYNC) ? 1'b1 :
                       (pll_mode != prsc_pkg::PLL_PD_SYNC)  ? 1'b0 :
                       (pll_pd_q | ((pll_arm_q | upd_q) & i_cp_event));

    always_ff @(posedge i_ref_clk) begin
        if (stage_rst) begin
            pll_pd_q  <= 1'b0;
            pll_arm_q <= 1'b0;
            upd_q     <= 1'b0;
        end else begin
            pll_pd_q  <= pll_pd_d;
            pll_arm_q <= pll_arm_d;
            upd_q     <= update;
        end
    end

    // ------------------------------------------------------------
    // output power-down
    // ------------------------------------------------------------
    logic                        dist_pd;
    logic [prsc_pkg::N_OUTS-1:0] out_off;
    prsc_pkg::prsc_power_t       power_d;
    prsc_pkg::prsc_power_t       power_q;

    assign dist_pd = fsp_act[prsc_pkg::BIT_DIST_PD];

    generate
        for (g = 0; g < prsc_pkg::N_OUTS; g++) begin : g_out
            logic own_pd;
            if (g < prsc_pkg::N_PECL) begin : g_pecl
                logic [1:0] mode;
                assign mode = bank_act[prsc_pkg::IDX_OUT0 + g]
                                      [prsc_pkg::LSB_PECL_MODE +: 2];
                assign own_pd = (mode != prsc_pkg::PECL_NORMAL);
                // mode also shapes the output under distribution power-down
                assign power_d.pecl_mode[g] =
                    sleep ? prsc_pkg::PECL_SAFE_OFF : mode;
            end else begin : g_cmos
                assign own_pd = bank_act[prsc_pkg::IDX_OUT0 + g]
                                        [prsc_pkg::BIT_CMOS_PD];
            end
            assign out_off[g] = own_pd | dist_pd | sleep;
        end
    endgenerate

    assign power_d.pll_off      = pll_pd_q | sleep;
    assign power_d.dist_off     = dist_pd;
    assign power_d.clocks_off   = sleep;
    assign power_d.dividers_off = sleep;
    assign power_d.sync_hold    = sync_hold & ~sleep;
    assign power_d.out_off      = out_off;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            power_q <= '0;
        end else begin
            power_q <= power_d;
        end
    end

    // ------------------------------------------------------------
    // multichip slow-clock coincidence monitor
    // ------------------------------------------------------------
    prsc_pkg::prsc_mon_t mon_q;
    prsc_pkg::prsc_mon_t mon_d;
    logic [1:0]          sep_q;
    logic [1:0]          sep_d;
    logic                flag_q;
    logic                flag_d;
    logic                mc_en;
    logic                mon_clr;
    logic [1:0]          win;
    logic                late;

    assign mc_en   = fsp_act[prsc_pkg::BIT_MC_SYNC_EN];
    // sync circuits are off in sleep; a held sync restarts the comparison
    assign mon_clr = ~mc_en | sleep | sync_hold;
    assign win     = fsp_act[prsc_pkg::BIT_SYNC_WIN] ?
                     prsc_pkg::SYNC_WIN_NARROW_CYC :
                     prsc_pkg::SYNC_WIN_WIDE_CYC;
    // separation only resolves to whole cycles of the sampling clock
    assign late    = (sep_q >= win);

    always_comb begin
        mon_d  = mon_q;
        sep_d  = sep_q;
        flag_d = flag_q;
        case (mon_q)
            prsc_pkg::MON_IDLE: begin
                sep_d = 2'h0;
                if (ref_rise & aux_rise) begin
                    flag_d = 1'b0;
                end else if (ref_rise) begin
                    mon_d = prsc_pkg::MON_WAIT_AUX;
                end else if (aux_rise) begin
                    mon_d = prsc_pkg::MON_WAIT_REF;
                end
            end
            prsc_pkg::MON_WAIT_REF,
            prsc_pkg::MON_WAIT_AUX: begin
                if ((mon_q == prsc_pkg::MON_WAIT_REF) ? ref_rise : aux_rise) begin
                    flag_d = late;
                    mon_d  = prsc_pkg::MON_IDLE;
                end else if (late) begin
                    flag_d = 1'b1;
                    mon_d  = prsc_pkg::MON_IDLE;
                end else begin
                    sep_d = sep_q + 2'h1;
                end
            end
            default: begin
                mon_d = prsc_pkg::MON_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (stage_rst | mon_clr) begin
            mon_q  <= prsc_pkg::MON_IDLE;
            sep_q  <= 2'h0;
            flag_q <= 1'b0;
        end else begin
            mon_q  <= mon_d;
            sep_q  <= sep_d;
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic status_q;
    logic sleep_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            status_q <= 1'b0;
            sleep_q  <= 1'b0;
        end else begin
            status_q <= mc_en & flag_q;
            sleep_q  <= sleep;
        end
    end

    assign o_rd_data    = rd_q;
    assign o_status     = status_q;
    assign o_sleep      = sleep_q;
    assign o_sdo_enable = cfg_q[prsc_pkg::BIT_SDO_EN];
    assign o_lsb_first  = cfg_q[prsc_pkg::BIT_LSB_FIRST];
    assign o_power      = power_q;

endmodule : prsc_top

`default_nettype wire

// [prsc_props.sv]
/*
 * prsc_props: port-level checks of prsc_top.
 * assumes: bound to every prsc_top; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module prsc_props (
    input wire logic                    i_ref_clk,
    input wire logic                    i_rst,
    input wire prsc_pkg::prsc_reg_req_t i_req,
    input wire logic [6:0]              i_rd_addr,
    input wire logic [7:0]              o_rd_data,
    input wire logic                    i_function_pin,
    input wire logic                    o_sleep,
    input wire logic                    o_sdo_enable,
    input wire logic                    o_lsb_first,
    input wire prsc_pkg::prsc_power_t   o_power
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    rst_clears_a: assert property (disable iff (1'b0) i_rst |=>
        o_rd_data == 8'h00 && !o_sdo_enable && !o_lsb_first && !o_sleep && o_power == '0)
        else $error("outputs not cleared by reset");
    cfg_write_a: assert property (i_req.wr && i_req.addr == prsc_pkg::ADDR_SPORT_CFG
        && i_function_pin && $past(i_function_pin) && $past(i_function_pin, 2)
        |=> {o_sdo_enable, o_lsb_first} == $past(i_req.wdata[7:6])) else $error("cfg write lost");
    sdo_cause_a: assert property ($changed(o_sdo_enable) |->
        $past(i_req.wr && i_req.addr == prsc_pkg::ADDR_SPORT_CFG) || !$past(i_function_pin, 2)
        || !$past(i_function_pin, 3)) else $error("sdo enable changed without cause");
    rd_unmapped_a: assert property (i_rd_addr == prsc_pkg::ADDR_UPDATE || i_rd_addr == 7'h7f
        |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
    rd_cfg_a: assert property (i_rd_addr == prsc_pkg::ADDR_SPORT_CFG && !i_req.wr
        && i_function_pin && $past(i_function_pin) && $past(i_function_pin, 2)
        |=> o_rd_data[7:6] == {o_sdo_enable, o_lsb_first}) else $error("cfg read mismatch");
    sleep_off_a: assert property (o_sleep && $past(o_sleep) |->
        o_power.pll_off && o_power.clocks_off && o_power.dividers_off && o_power.out_off == 8'hff)
        else $error("block running while asleep");
    sleep_pecl_a: assert property (o_sleep && $past(o_sleep) |-> o_power.pecl_mode == 8'haa)
        else $error("lvpecl not safe-off in sleep");
    sleep_nosync_a: assert property (o_sleep && $past(o_sleep) |-> !o_power.sync_hold)
        else $error("sync circuit on in sleep");
    sleep_cause_a: assert property ($rose(o_sleep) |-> !$past(i_function_pin, 2)
        || !$past(i_function_pin, 3)) else $error("sleep without low pin");
    wake_cause_a: assert property ($fell(o_sleep) |-> $past(i_function_pin, 2)
        || $past(i_function_pin, 3) || $past(i_rst)) else $error("woke with pin low");
endmodule : prsc_props

bind prsc_top prsc_props u_prsc_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req),
    .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .i_function_pin(i_function_pin),
    .o_sleep(o_sleep), .o_sdo_enable(o_sdo_enable), .o_lsb_first(o_lsb_first),
    .o_power(o_power));

`default_nettype wire

// [prsc_peer_model.sv]
/*
 * prsc_peer_model: slow clock from the master chip and its slave loop-back.
 * assumes: runs from the fast clock; skew given in fast cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module prsc_peer_model (
    input  wire logic       i_ref_clk,
    input  wire logic [2:0] i_skew,
    output logic            o_ref,
    output logic            o_aux
);
    logic [2:0] cnt_q = 3'h0;
    initial begin
        o_ref = 1'b0;
        o_aux = 1'b0;
    end
    // period of eight fast cycles keeps the slow clock under a quarter rate
    always @(posedge i_ref_clk) begin
        cnt_q <= cnt_q + 3'h1;
        o_ref <= cnt_q < 3'h4;
        o_aux <= 3'(cnt_q - i_skew) < 3'h4;
    end
endmodule : prsc_peer_model

`default_nettype wire

// [testbench.sv]
/*
 * testbench: self-checking bench of prsc_top against a register model.
 * assumes: prsc_props binds itself; the peer model makes the slow clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    pin = 1'b1;
    logic                    cp = 1'b0;
    logic [6:0]              ra = 7'h00;
    logic [2:0]              skew = 3'h0;
    prsc_pkg::prsc_reg_req_t req = '0;
    prsc_pkg::prsc_power_t   pw;
    logic [7:0]              rd;
    logic [7:0]              bf [128];
    logic [7:0]              act [128];
    logic [1:0]              pc [3] = '{2'h0, 2'h2, 2'h3};
    logic                    sts, slp, sdo, lsb, sref, saux;
    int                      fail_count = 0;
    int                      checked = 0;
    int                      i;

    always #12.5 clk = ~clk;
    prsc_top u_prsc_top (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_rd_addr(ra),
        .o_rd_data(rd), .i_function_pin(pin), .i_reference_input(sref),
        .i_aux_clock_input(saux), .i_cp_event(cp), .o_status(sts), .o_sleep(slp),
        .o_sdo_enable(sdo), .o_lsb_first(lsb), .o_power(pw));
    prsc_peer_model u_prsc_peer_model (.i_ref_clk(clk), .i_skew(skew), .o_ref(sref),
        .o_aux(saux));

    // ------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : ck
    function automatic logic mapped(input logic [6:0] a);
        return a == 7'h0a || (a >= 7'h3c && a <= 7'h43) || a == 7'h58;
    endfunction : mapped
    task automatic clr(input logic all);
        for (int k = 0; k < 128; k++) if (all || k > 0) begin
            bf[k] = 8'h00;
            act[k] = 8'h00;
        end
    endtask : clr
    // soft reset keeps the bank cleared, so writes and updates meanwhile are lost
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk) req = '{1'b1, a, d};
        @(negedge clk) req.wr = 1'b0;
        if (a == 7'h00) bf[0] = d;
        else if (mapped(a) && !bf[0][5]) bf[a] = d;
        if (a == 7'h5a && d[0] && !bf[0][5]) act = bf;
        if (bf[0][5]) clr(1'b0);
    endtask : wr
    task automatic rdck(input logic [6:0] a);
        @(negedge clk) ra = a;
        @(negedge clk) ck(rd, a == 7'h00 ? bf[0] : mapped(a) ? bf[a] : 8'h00);
    endtask : rdck
    task automatic pwck();
        repeat (3) @(negedge clk);
        for (int k = 0; k < 4; k++) begin
            ck(pw.pecl_mode[k], act[7'h3c + k][1:0]);
            ck(pw.out_off[4 + k], act[7'h40 + k][0]);
        end
        ck({pw.dist_off, pw.sync_hold, pw.pll_off}, {act[7'h58][3:2], act[7'h0a][1:0] == 2'h1});
    endtask : pwck

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #(25 * 20000);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(16));
        clr(1'b1);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 128; i++) rdck(i[6:0]);
        wr(7'h00, 8'hc0);
        ck({sdo, lsb}, 2'h3);
        wr(7'h00, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(7'h3c + i[6:0], {6'h0, pc[$urandom % 3]});
            wr(7'h40 + i[6:0], 8'($urandom % 2));
        end
        pwck();
        wr(7'h5a, 8'h01);
        pwck();
        for (i = 0; i < 8; i++) rdck(7'h3c + i[6:0]);
        for (i = 0; i < 4; i++) begin
            wr(7'h0a, 8'(i));
            wr(7'h5a, 8'h01);
            pwck();
        end
        @(negedge clk) cp = 1'b1;
        @(negedge clk) cp = 1'b0;
        repeat (2) @(negedge clk);
        ck(pw.pll_off, 1'b1);
        wr(7'h0a, 8'h00);
        wr(7'h58, 8'h08);
        wr(7'h5a, 8'h01);
        repeat (3) @(negedge clk);
        ck(pw.dist_off, 1'b1);
        wr(7'h58, 8'h04);
        wr(7'h5a, 8'h01);
        pwck();
        wr(7'h58, 8'h20);
        wr(7'h5a, 8'h01);
        pwck();
        pin = 1'b0;
        repeat (5) @(negedge clk);
        ck(pw.sync_hold, 1'b1);
        pin = 1'b1;
        repeat (5) @(negedge clk);
        ck(pw.sync_hold, 1'b0);
        wr(7'h58, 8'h60);
        wr(7'h5a, 8'h01);
        pin = 1'b0;
        repeat (5) @(negedge clk);
        ck({slp, pw.pecl_mode}, 9'h1aa);
        wr(7'h0a, 8'h01);
        rdck(7'h0a);
        wr(7'h5a, 8'h01);
        ck(slp, 1'b1);
        pin = 1'b1;
        repeat (5) @(negedge clk);
        ck(slp, 1'b0);
        pwck();
        wr(7'h58, 8'h64);
        wr(7'h5a, 8'h01);
        pwck();
        wr(7'h00, 8'h20);
        wr(7'h0a, 8'h03);
        rdck(7'h0a);
        rdck(7'h00);
        pwck();
        wr(7'h00, 8'h40);
        wr(7'h0a, 8'h01);
        rdck(7'h0a);
        pin = 1'b0;
        repeat (4) @(negedge clk);
        pin = 1'b1;
        clr(1'b1);
        repeat (3) @(negedge clk);
        rdck(7'h0a);
        ck({sdo, lsb}, 2'h0);
        for (i = 0; i < 7; i++) begin
            wr(7'h58, i < 6 ? 8'h21 | 8'(i / 3 * 2) : 8'h00);
            wr(7'h5a, 8'h01);
            skew = i < 6 ? 3'(i % 3) : 3'h3;
            repeat (40) @(negedge clk);
            ck(sts, i < 6 && i % 3 > (i < 3));
            if (i < 6) begin
                pin = 1'b0;
                skew = 3'h0;
                repeat (4) @(negedge clk);
                pin = 1'b1;
                repeat (40) @(negedge clk);
                ck(sts, 1'b0);
            end
        end
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
